// ==== logic/rsc_pkg.sv ====
/*
 * constants, codes and message texts for the serial command front end.
 * assumes a 40 MHz system clock and ascii traffic on an 8n1 link.
 */
package rsc_pkg;

    // ****************************************************************
    // clocking and link timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned BAUD_RATE = 9600;
    // cycles per bit, rounded to nearest (about 0.01 % error)
    localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    // cycles granted to the checksum level synchroniser before sampling
    localparam logic [1:0] START_WAIT = 2'h3;

    // ****************************************************************
    // characters and command keys {digit count, bcd digits}
    // ****************************************************************
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [18:0] CMD_ENTER = {3'h2, 16'h0001};
    localparam logic [18:0] CMD_LEAVE = {3'h2, 16'h0000};
    localparam logic [18:0] CMD_VERSION = {3'h3, 16'h0505};
    localparam logic [18:0] CMD_RF_ON = {3'h4, 16'h6401};
    localparam logic [18:0] CMD_RF_OFF = {3'h4, 16'h6400};
    localparam logic [18:0] CMD_ALL_IDS = {3'h2, 16'h0040};

    // ****************************************************************
    // serial number layout
    // ****************************************************************
    localparam int unsigned LABEL_LEN = 7;
    localparam int unsigned SN_LEN = 6;
    localparam int unsigned SN_SKIP = 3;
    localparam logic [47:0] SN_BLANK = {6{CH_ZERO}};

    // ****************************************************************
    // message texts and lengths
    // ****************************************************************
    localparam logic [95:0] TXT_HEAD = "RDR V1.00 SN";
    localparam logic [103:0] TXT_VHEAD = "#RDR V1.00 SN";
    localparam logic [95:0] TXT_NOTICE = "(C) RESERVED";
    localparam logic [151:0] TXT_BOOT = "RDR BOOT Ver 0.00 E";
    localparam logic [39:0] TXT_DONE = "#Done";
    localparam logic [5:0] LEN_SIGNON = 6'h22;
    localparam logic [5:0] LEN_BOOT = 6'h23;
    localparam logic [5:0] LEN_DONE = 6'h07;
    localparam logic [5:0] LEN_VERSION = 6'h15;
    localparam logic [5:0] LEN_TAG = 6'h06;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [2:0] {
        MSG_SIGNON = 3'b000,
        MSG_BOOT = 3'b001,
        MSG_DONE = 3'b010,
        MSG_VERSION = 3'b011,
        MSG_TAG = 3'b100
    } rsc_msg_type;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_RUN = 2'b01,
        ST_DOWNLOAD = 2'b10
    } rsc_state_type;

endpackage

// ==== logic/rsc_front_end.sv ====
/*
 * serial command front end: uart receive and transmit, '#' command
 * parser, mode flags and the text replies of the reader.
 * assumes the rx pin is asynchronous, the tag inputs and the label
 * serial number come from logic on sys_clk, and the label is stable
 * from reset release onward.
 */
// How it works
// - the link runs at 9600 baud, 8 data bits, no parity, one stop bit.
// - after reset a sign-on line with model, version and SN number goes out.
// - the reported serial number is the label number minus its 4th char.
// - an all-zero serial number is reported as is and flagged invalid.
// - a failed program checksum swaps the sign-on for a boot text 0.00.
// - on a failed checksum no serial is sent and download mode is held.
// - command 01 and carriage return enter command mode with '#Done'.
// - command 505 in command mode returns model, version and serial.
// - command 00 returns to data mode with '#Done'.
// - in data mode each matching tag read goes out as its own line, except one arriving while another tag is held, which is dropped.
// - command 6401 turns the rf on and 6400 turns it off.
// - after command 40 every tag id is reported without uniqueness.
`timescale 1ns/1ps

module rsc_front_end #(
    parameter int unsigned bit_cycles = rsc_pkg::BIT_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial link pins
    input wire logic rx_pin,
    output logic tx_pin,
    // startup information
    input wire logic checksum_ok,
    input wire logic [8*rsc_pkg::LABEL_LEN-1:0] label_sn,
    // tag reads from the decoder
    input wire logic tag_strobe,
    input wire logic [15:0] tag_id,
    input wire logic tag_protocol_ok,
    input wire logic tag_repeat,
    // mode outputs
    output logic command_mode,
    output logic rf_on,
    output logic transmit_all,
    output logic download_mode,
    output logic sn_invalid
);

    localparam logic [12:0] BIT_LAST = 13'(bit_cycles - 1);
    localparam logic [12:0] HALF_LAST = 13'(bit_cycles / 2 - 1);

    // ****************************************************************
    // declarations
    // ****************************************************************
    rsc_pkg::rsc_state_type state;
    logic [1:0] start_cnt;
    logic [2:0] rx_sync;
    logic [2:0] ck_sync;
    logic rx_busy;
    logic [12:0] rx_timer;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_valid;
    logic parse_on;
    logic [2:0] dig_cnt;
    logic [15:0] dig_bcd;
    logic [47:0] sn;
    logic [15:0] tag_held;
    logic tag_pending;
    logic reply_pending;
    rsc_pkg::rsc_msg_type reply_sel;
    logic msg_active;
    rsc_pkg::rsc_msg_type msg_sel;
    logic [5:0] msg_idx;
    logic [5:0] msg_len;
    logic [7:0] msg_byte;
    logic [9:0] tx_shift;
    logic [12:0] tx_timer;
    logic [3:0] tx_bits;
    logic tx_busy;

    // ****************************************************************
    // decode wires
    // ****************************************************************
    wire rx_fall = rx_sync[2] & ~rx_sync[1];
    wire is_digit = rx_shift inside {[rsc_pkg::CH_ZERO:rsc_pkg::CH_NINE]};
    wire cmd_go = rx_valid && parse_on && rx_shift == rsc_pkg::CH_CR;
    wire [18:0] cmd_key = {dig_cnt, dig_bcd};
    wire run = state == rsc_pkg::ST_RUN;
    wire do_enter = cmd_go && run && cmd_key == rsc_pkg::CMD_ENTER;
    wire do_leave = cmd_go && run && cmd_key == rsc_pkg::CMD_LEAVE;
    wire do_ver = cmd_go && run && command_mode
                  && cmd_key == rsc_pkg::CMD_VERSION;
    wire do_rf_on = cmd_go && run && command_mode
                    && cmd_key == rsc_pkg::CMD_RF_ON;
    wire do_rf_off = cmd_go && run && command_mode
                     && cmd_key == rsc_pkg::CMD_RF_OFF;
    wire do_all = cmd_go && run && command_mode
                  && cmd_key == rsc_pkg::CMD_ALL_IDS;
    wire do_done = do_enter | do_leave | do_rf_on | do_rf_off | do_all;
    // tags pass only in data mode, protocol matched, unique unless all
    wire tag_take = tag_strobe && run && !command_mode && !tag_pending
                    && tag_protocol_ok && (transmit_all || !tag_repeat);
    wire msg_start = !msg_active && (reply_pending || tag_pending);
    wire load_byte = msg_active && !tx_busy;

    // ****************************************************************
    // message text selection
    // ****************************************************************
    function automatic logic [7:0] txt(input logic [255:0] s,
                                       input logic [5:0] len,
                                       input logic [5:0] i);
        txt = s[8*(len-i-6'h01) +: 8];
    endfunction

    function automatic logic [7:0] hex(input logic [3:0] n);
        hex = n < 4'ha ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    wire [5:0] sn_pos = msg_sel == rsc_pkg::MSG_SIGNON ? msg_idx - 6'h0c
                                                        : msg_idx - 6'h0d;
    wire [7:0] sn_char = sn[8*(6'h05-sn_pos[2:0]) +: 8];
    wire [7:0] tag_char = hex(tag_held[4*(2'h3-msg_idx[1:0]) +: 4]);

    // one character per index for the message in flight
    always_comb begin
        msg_byte = rsc_pkg::CH_LF;
        case (msg_sel)
            rsc_pkg::MSG_SIGNON: begin
                if (msg_idx < 6'h0c)
                    msg_byte = txt(256'(rsc_pkg::TXT_HEAD), 6'h0c, msg_idx);
                else if (msg_idx < 6'h12)
                    msg_byte = sn_char;
                else if (msg_idx == 6'h12 || msg_idx == 6'h20)
                    msg_byte = rsc_pkg::CH_CR;
                else if (msg_idx > 6'h13 && msg_idx < 6'h20)
                    msg_byte = txt(256'(rsc_pkg::TXT_NOTICE), 6'h0c,
                                   msg_idx - 6'h14);
            end
            rsc_pkg::MSG_BOOT: begin // no serial slot at all
                if (msg_idx < 6'h13)
                    msg_byte = txt(256'(rsc_pkg::TXT_BOOT), 6'h13, msg_idx);
                else if (msg_idx == 6'h13 || msg_idx == 6'h21)
                    msg_byte = rsc_pkg::CH_CR;
                else if (msg_idx > 6'h14 && msg_idx < 6'h21)
                    msg_byte = txt(256'(rsc_pkg::TXT_NOTICE), 6'h0c,
                                   msg_idx - 6'h15);
            end
            rsc_pkg::MSG_DONE: begin
                if (msg_idx < 6'h05)
                    msg_byte = txt(256'(rsc_pkg::TXT_DONE), 6'h05, msg_idx);
                else if (msg_idx == 6'h05)
                    msg_byte = rsc_pkg::CH_CR;
            end
            rsc_pkg::MSG_VERSION: begin
                if (msg_idx < 6'h0d)
                    msg_byte = txt(256'(rsc_pkg::TXT_VHEAD), 6'h0d, msg_idx);
                else if (msg_idx < 6'h13)
                    msg_byte = sn_char;
                else if (msg_idx == 6'h13)
                    msg_byte = rsc_pkg::CH_CR;
            end
            default: begin
                if (msg_idx < 6'h04)
                    msg_byte = tag_char;
                else if (msg_idx == 6'h04)
                    msg_byte = rsc_pkg::CH_CR;
            end
        endcase
    end

    // ****************************************************************
    // startup: checksum synchroniser, strap capture, first message
    // ****************************************************************
    // the serial is caught once after release; later label edits are
    // ignored until the next reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ck_sync <= 3'h0;
            start_cnt <= 2'h0;
            state <= rsc_pkg::ST_START;
            sn <= rsc_pkg::SN_BLANK;
            sn_invalid <= 1'b0;
            download_mode <= 1'b0;
        end else begin
            ck_sync <= {ck_sync[1:0], checksum_ok};
            if (state == rsc_pkg::ST_START) begin
                start_cnt <= start_cnt + 2'h1;
                if (start_cnt == rsc_pkg::START_WAIT) begin
                    if (ck_sync[1]) begin
                        state <= rsc_pkg::ST_RUN;
                        sn <= {label_sn[55:32], label_sn[23:0]};
                        sn_invalid <= {label_sn[55:32], label_sn[23:0]}
                                      == rsc_pkg::SN_BLANK;
                    end else begin
                        state <= rsc_pkg::ST_DOWNLOAD;
                        download_mode <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // uart receiver, 8n1, samples mid-bit
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync <= 3'h7;
            rx_busy <= 1'b0;
            rx_timer <= 13'h0;
            rx_bits <= 4'h0;
            rx_shift <= 8'h0;
            rx_valid <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_pin};
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (rx_fall) begin
                    rx_busy <= 1'b1;
                    rx_timer <= HALF_LAST;
                    rx_bits <= 4'h0;
                end
            end else if (rx_timer != 13'h0) begin
                rx_timer <= rx_timer - 13'h1;
            end else begin
                rx_timer <= BIT_LAST;
                rx_bits <= rx_bits + 4'h1;
                if (rx_bits == 4'h0 && rx_sync[2])
                    rx_busy <= 1'b0; // glitch, not a start bit
                else if (rx_bits > 4'h0 && rx_bits < 4'h9)
                    rx_shift <= {rx_sync[2], rx_shift[7:1]};
                else if (rx_bits == 4'h9) begin
                    rx_busy <= 1'b0;
                    rx_valid <= rx_sync[2]; // framing error drops byte
                end
            end
        end
    end

    // ****************************************************************
    // command parser and mode flags
    // ****************************************************************
    // a fifth digit or any stray character abandons the command
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            parse_on <= 1'b0;
            dig_cnt <= 3'h0;
            dig_bcd <= 16'h0;
            command_mode <= 1'b0;
            rf_on <= 1'b0;
            transmit_all <= 1'b0;
        end else begin
            if (rx_valid) begin
                if (rx_shift == rsc_pkg::CH_HASH) begin
                    parse_on <= 1'b1;
                    dig_cnt <= 3'h0;
                    dig_bcd <= 16'h0;
                end else if (parse_on && is_digit && dig_cnt < 3'h4) begin
                    dig_cnt <= dig_cnt + 3'h1;
                    dig_bcd <= {dig_bcd[11:0], rx_shift[3:0]};
                end else begin
                    parse_on <= 1'b0;
                end
            end
            if (do_enter)
                command_mode <= 1'b1;
            if (do_leave)
                command_mode <= 1'b0;
            if (do_rf_on)
                rf_on <= 1'b1;
            if (do_rf_off)
                rf_on <= 1'b0;
            if (do_all)
                transmit_all <= 1'b1;
        end
    end

    // ****************************************************************
    // reply and tag holding, message sequencer
    // ****************************************************************
    // one reply slot: the host waits for each answer before the next
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_pending <= 1'b0;
            reply_sel <= rsc_pkg::MSG_SIGNON;
            tag_pending <= 1'b0;
            tag_held <= 16'h0;
            msg_active <= 1'b0;
            msg_sel <= rsc_pkg::MSG_SIGNON;
            msg_idx <= 6'h0;
            msg_len <= 6'h0;
        end else begin
            if (state == rsc_pkg::ST_START
                && start_cnt == rsc_pkg::START_WAIT) begin
                reply_pending <= 1'b1;
                reply_sel <= ck_sync[1] ? rsc_pkg::MSG_SIGNON
                                        : rsc_pkg::MSG_BOOT;
            end else if (do_done || do_ver) begin
                reply_pending <= 1'b1;
                reply_sel <= do_ver ? rsc_pkg::MSG_VERSION
                                    : rsc_pkg::MSG_DONE;
            end else if (msg_start) begin
                reply_pending <= 1'b0;
            end
            if (tag_take) begin
                tag_pending <= 1'b1;
                tag_held <= tag_id;
            end else if (msg_start && !reply_pending) begin
                tag_pending <= 1'b0;
            end
            if (msg_start) begin
                msg_active <= 1'b1;
                msg_idx <= 6'h0;
                msg_sel <= reply_pending ? reply_sel : rsc_pkg::MSG_TAG;
                case (reply_pending ? reply_sel : rsc_pkg::MSG_TAG)
                    rsc_pkg::MSG_SIGNON: msg_len <= rsc_pkg::LEN_SIGNON;
                    rsc_pkg::MSG_BOOT: msg_len <= rsc_pkg::LEN_BOOT;
                    rsc_pkg::MSG_DONE: msg_len <= rsc_pkg::LEN_DONE;
                    rsc_pkg::MSG_VERSION: msg_len <= rsc_pkg::LEN_VERSION;
                    default: msg_len <= rsc_pkg::LEN_TAG;
                endcase
            end else if (load_byte) begin
                msg_idx <= msg_idx + 6'h1;
                if (msg_idx == msg_len - 6'h1)
                    msg_active <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // uart transmitter, 8n1, lsb first
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift <= 10'h3ff;
            tx_timer <= 13'h0;
            tx_bits <= 4'h0;
            tx_busy <= 1'b0;
            tx_pin <= 1'b1;
        end else begin
            if (load_byte) begin
                tx_shift <= {1'b1, msg_byte, 1'b0};
                tx_busy <= 1'b1;
                tx_timer <= BIT_LAST;
                tx_bits <= 4'h0;
                tx_pin <= 1'b0;
            end else if (tx_busy) begin
                if (tx_timer != 13'h0) begin
                    tx_timer <= tx_timer - 13'h1;
                end else if (tx_bits == 4'h9) begin
                    tx_busy <= 1'b0;
                end else begin
                    tx_timer <= BIT_LAST;
                    tx_bits <= tx_bits + 4'h1;
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_pin <= tx_shift[1];
                end
            end
        end
    end

endmodule

// ==== tb/rsc_checker.sv ====
/* assertions on the ports of the serial command front end.
   assumes binding to rsc_front_end, one clock, async low reset. */
`timescale 1ns/1ps
module rsc_checker #(
    parameter int unsigned bit_cycles = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial pins
    input wire logic rx_pin,
    input wire logic tx_pin,
    // startup and tags
    input wire logic checksum_ok,
    input wire logic [8*rsc_pkg::LABEL_LEN-1:0] label_sn,
    input wire logic tag_strobe,
    input wire logic [15:0] tag_id,
    input wire logic tag_protocol_ok,
    input wire logic tag_repeat,
    // modes
    input wire logic command_mode,
    input wire logic rf_on,
    input wire logic transmit_all,
    input wire logic download_mode,
    input wire logic sn_invalid
);
    // ********************
    // helpers and sequences
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] low_run;
    // length of the current low run; each run must be whole bits
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            low_run <= 16'h0000;
        else if (!tx_pin)
            low_run <= low_run + 16'h0001;
        else
            low_run <= 16'h0000;
    end
    sequence start_bit;
        $fell(tx_pin) ##1 !tx_pin [*8];
    endsequence
    sequence reply_start;
        ##[1:4] start_bit;
    endsequence

    a_reset_idle_line: assert property (
        $rose(reset_n) |-> tx_pin && !command_mode && !rf_on
        && !transmit_all && !download_mode)
        else $error("outputs not idle after reset");
    a_whole_bit_times: assert property (
        $rose(tx_pin) |-> (low_run % bit_cycles) == 0)
        else $error("tx low run not whole bits");
    a_enter_reply: assert property (
        $rose(command_mode) |-> reply_start)
        else $error("no reply on entering command mode");
    a_leave_reply: assert property (
        $fell(command_mode) |-> reply_start)
        else $error("no reply on leaving command mode");
    a_mode_after_frame: assert property (
        $changed(command_mode) |-> $past(rx_pin, 2) && $past(rx_pin, 4))
        else $error("mode changed while rx busy");
    a_download_held: assert property (
        download_mode |=> download_mode)
        else $error("download mode dropped");
    a_download_dead: assert property (
        download_mode |-> !command_mode && !rf_on && !transmit_all)
        else $error("commands obeyed in download mode");
    a_rf_in_cmd: assert property (
        $changed(rf_on) |-> command_mode)
        else $error("rf changed outside command mode");
    a_all_ids_kept: assert property (
        transmit_all |=> transmit_all)
        else $error("transmit all dropped");
    a_all_ids_cmd: assert property (
        $rose(transmit_all) |-> command_mode)
        else $error("transmit all set outside command mode");
    a_blank_serial: assert property (
        $rose(sn_invalid) |-> label_sn[55:32] == 24'h303030
        && label_sn[23:0] == 24'h303030)
        else $error("invalid flag on nonzero serial");
endmodule

// ==== tb/rsc_host.sv ====
/* host terminal model: 8n1 sender on the reader's rx line and
   receiver of the reader's tx line into a byte queue.
   assumes sys_clk paces the bits, bit_cycles clocks per bit. */
`timescale 1ns/1ps
module rsc_host #(
    parameter int unsigned bit_cycles = 16
) (
    // clock
    input wire logic sys_clk,
    // serial pins seen from the host
    output logic host_tx,
    input wire logic host_rx
);
    logic [7:0] rx_q[$];
    logic [7:0] rb;
    int bad_stop = 0;
    initial host_tx = 1'b1; // mark level between frames
    // one frame lsb first, no parity, one stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            #1;
            host_tx = f[i];
            repeat (bit_cycles - 1) @(posedge sys_clk);
        end
    endtask
    // config goes over this port even in wiegand use
    task automatic send_cmd(input string digits);
        send_byte(8'h23);
        foreach (digits[i]) send_byte(digits[i]);
        send_byte(8'h0d);
    endtask
    // mid-bit sampling; a frame with a bad stop bit is counted
    always begin
        @(negedge host_rx);
        repeat (bit_cycles / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge sys_clk);
            rb[i] = host_rx;
        end
        repeat (bit_cycles) @(posedge sys_clk);
        if (host_rx) rx_q.push_back(rb);
        else bad_stop++;
    end
endmodule

// ==== tb/testbench.sv ====
/* self-checking bench for the serial command front end.
   assumes rsc_pkg, rsc_front_end, rsc_host and rsc_checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    fail_count++; end end
module testbench;
    // ********************
    // bench signals
    // ********************
    localparam int unsigned BC = 16; // short bit time keeps runs brief
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic rx_pin, tx_pin, checksum_ok = 1'b1;
    logic [55:0] label_sn = "1234567";
    logic tag_strobe = 1'b0, tag_protocol_ok = 1'b0, tag_repeat = 1'b0;
    logic [15:0] tag_id = 16'h0000;
    logic command_mode, rf_on, transmit_all, download_mode, sn_invalid;
    int fail_count = 0, n_tests = 0;
    string nl = "\r\n", head, note;
    always #12.5 sys_clk = ~sys_clk;
    rsc_host #(.bit_cycles(BC)) host (.sys_clk(sys_clk),
        .host_tx(rx_pin), .host_rx(tx_pin));
    rsc_front_end #(.bit_cycles(BC)) uut (.sys_clk(sys_clk),
        .reset_n(reset_n), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .checksum_ok(checksum_ok), .label_sn(label_sn),
        .tag_strobe(tag_strobe), .tag_id(tag_id),
        .tag_protocol_ok(tag_protocol_ok), .tag_repeat(tag_repeat),
        .command_mode(command_mode), .rf_on(rf_on),
        .transmit_all(transmit_all), .download_mode(download_mode),
        .sn_invalid(sn_invalid));
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // reset held 4 cycles; checksum level settles long before release
    task automatic start(input logic ok, input logic [55:0] lab);
        checksum_ok = ok;
        label_sn = lab;
        reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        host.rx_q.delete();
        reset_n = 1'b1;
    endtask
    // bounded wait for the whole text, then byte by byte
    task automatic expect_text(input string s);
        int n;
        logic [7:0] c;
        n = 0;
        while (host.rx_q.size() < s.len() && n < (s.len() + 4) * 12 * BC)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (host.rx_q.size() < s.len()) begin
            fail_count++;
            results();
        end else begin
            foreach (s[i]) begin
                c = host.rx_q.pop_front();
                `CHK(c, 8'(s[i]))
            end
        end
    endtask
    // silence long enough for any line to have begun
    task automatic quiet();
        repeat (30 * BC) @(posedge sys_clk);
        `CHK(host.rx_q.size(), 0)
    endtask
    task automatic tag(input logic [15:0] id, input logic ok, rep);
        @(posedge sys_clk);
        #1;
        {tag_strobe, tag_id} = {1'b1, id};
        {tag_protocol_ok, tag_repeat} = {ok, rep};
        @(posedge sys_clk);
        #1;
        tag_strobe = 1'b0;
    endtask
    task automatic t_signon();
        expect_text({head, "123567", nl, note, nl});
        `CHK(sn_invalid, 1'b0)
        `CHK(download_mode, 1'b0)
    endtask
    // filtered and foreign tags stay silent, good ones each get a line
    task automatic t_tags_data();
        tag(16'h1a2f, 1'b1, 1'b1);
        quiet();
        tag(16'h0b3c, 1'b0, 1'b0);
        quiet();
        tag(16'h1a2f, 1'b1, 1'b0);
        expect_text({"1A2F", nl});
        tag(16'hc0de, 1'b1, 1'b0);
        expect_text({"C0DE", nl});
        host.send_cmd("505");
        quiet();
        `CHK(command_mode, 1'b0)
    endtask
    // the continuous rf test sequence with an off in between
    task automatic t_commands();
        host.send_cmd("01");
        expect_text({"#Done", nl});
        `CHK(command_mode, 1'b1)
        host.send_cmd("505");
        expect_text({"#", head, "123567", nl});
        host.send_cmd("6401");
        expect_text({"#Done", nl});
        `CHK(rf_on, 1'b1)
        host.send_cmd("6400");
        expect_text({"#Done", nl});
        `CHK(rf_on, 1'b0)
        // each reply is awaited: one reply slot only
        host.send_cmd("6401");
        expect_text({"#Done", nl});
        host.send_cmd("40");
        expect_text({"#Done", nl});
        `CHK(transmit_all, 1'b1)
        host.send_cmd("00");
        expect_text({"#Done", nl});
        `CHK(command_mode, 1'b0)
        `CHK(rf_on, 1'b1)
        tag(16'h1a2f, 1'b1, 1'b1);
        expect_text({"1A2F", nl});
    endtask
    task automatic t_blank();
        start(1'b1, "0009000");
        expect_text({head, "000000", nl, note, nl});
        `CHK(sn_invalid, 1'b1)
    endtask
    // bad checksum: boot text, download mode, commands ignored
    task automatic t_boot();
        start(1'b0, "1234567");
        expect_text({string'(rsc_pkg::TXT_BOOT), nl, note, nl});
        `CHK(download_mode, 1'b1)
        host.send_cmd("01");
        quiet();
        `CHK(command_mode, 1'b0)
    endtask
    initial begin
        head = string'(rsc_pkg::TXT_HEAD);
        note = string'(rsc_pkg::TXT_NOTICE);
        start(1'b1, "1234567");
        t_signon();
        t_tags_data();
        t_commands();
        t_blank();
        t_boot();
        `CHK(host.bad_stop, 0)
        results();
    end
endmodule
bind rsc_front_end rsc_checker #(.bit_cycles(bit_cycles)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .checksum_ok(checksum_ok), .label_sn(label_sn),
    .tag_strobe(tag_strobe), .tag_id(tag_id),
    .tag_protocol_ok(tag_protocol_ok), .tag_repeat(tag_repeat),
    .command_mode(command_mode), .rf_on(rf_on),
    .transmit_all(transmit_all), .download_mode(download_mode),
    .sn_invalid(sn_invalid));
